/* dals_cfg.svh */
// Register offsets, field positions, reset values and settling counts
`ifndef DALS_CFG_SVH
`define DALS_CFG_SVH

// Register offsets on the plain register port
`define DALS_OFS_FILTER_CTRL 8'hda
`define DALS_OFS_PEAK_CTRL   8'hd9

// Field positions in modem_filter_control
`define DALS_BIT_MODEM_RST_N 0
`define DALS_BIT_PEAK_EN     1
`define DALS_BIT_SETTLE_LO   2
`define DALS_BIT_SETTLE_HI   3
`define DALS_BIT_LOCK_STAT   4
`define DALS_BIT_LOCK_MODE   5
`define DALS_BIT_LOCK_IN     6
`define DALS_BIT_RESERVED    7

// Field position of peak_level_offset in modem_peak_control
`define DALS_THR_HI 6

// Reset values: modem held in reset, automatic lock, peak remover off
`define DALS_RST_FILTER_CTRL 8'h00
`define DALS_RST_PEAK_CTRL   7'h00

// Automatic lock delay in baud periods per settling code
`define DALS_SETTLE_00 7'h0b
`define DALS_SETTLE_01 7'h16
`define DALS_SETTLE_10 7'h2b
`define DALS_SETTLE_11 7'h56

`endif

/* dals_pkg.sv */
// Types shared by the demodulator averaging, lock and slicer logic
package dals_pkg;

  // Automatic lock sequencer states
  typedef enum logic [1:0] {
    ST_FREE   = 2'b00,
    ST_SETTLE = 2'b01,
    ST_HOLD   = 2'b10
  } dals_lock_e;

  typedef logic [1:0] dals_settle_t;

endpackage

/* dals_avg.sv */
// Averaging filter: first-order tracker of the data DC level
`timescale 1ns/1ps
`default_nettype none

module dals_avg
  import dals_pkg::*;
#(
  parameter int W     = 10,
  parameter int SHIFT = 4
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Control
  input  wire logic                clr,
  input  wire logic                upd,
  // Data
  input  wire logic signed [W-1:0] din,
  output var  logic signed [W-1:0] level
);

  localparam int AW = W + SHIFT;

  logic signed [AW-1:0] acc_q;
  logic signed [AW-1:0] acc_d;
  logic signed [AW-1:0] din_ext;
  logic signed [AW-1:0] err;

  // Fractional bits equal the shift; settling from above is exact, from below it stops up to one LSB short
  always_comb begin
    din_ext = AW'(din) <<< SHIFT;
    err     = din_ext - acc_q;
    acc_d   = acc_q;
    if (clr) begin
      acc_d = '0;
    end else if (upd) begin
      acc_d = acc_q + (err >>> SHIFT);
    end
  end

  // Accumulator register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_d;
    end
  end

  assign level = acc_q[AW-1:SHIFT];

endmodule // dals_avg

`default_nettype wire

/* dals_top.sv */
// Demodulator data decision: peak remover, averaging lock and slicer
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "dals_cfg.svh"

module dals_top
  import dals_pkg::*;
#(
  parameter int SAMPLE_W  = 10,
  parameter int AVG_SHIFT = 4
) (
  // Clock and reset
  input  wire logic                       CLK_SYS,
  input  wire logic                       RST,
  // Register port
  input  wire logic [7:0]                 REG_ADDR,
  input  wire logic [7:0]                 REG_WDATA,
  input  wire logic                       REG_WR,
  input  wire logic                       REG_RD,
  output var  logic [7:0]                 REG_RDATA,
  // Main RF control levels
  input  wire logic                       MAIN_RESET_N,
  input  wire logic                       RX_POWER_DOWN,
  // Baud timing and detected frequency samples
  input  wire logic                       BAUD_TICK,
  input  wire logic                       SAMPLE_VALID,
  input  wire logic signed [SAMPLE_W-1:0] SAMPLE,
  // Decisions and status
  output var  logic                       DATA_OUT,
  output var  logic                       DATA_VALID,
  output var  logic                       AVG_LOCKED,
  output var  logic signed [SAMPLE_W-1:0] AVG_LEVEL
);

  localparam int DW = SAMPLE_W + 1;

  // Register state
  logic [6:0] ctl_q;
  logic [6:0] ctl_d;
  logic [6:0] ofs_q;
  logic [6:0] ofs_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Lock state
  dals_lock_e st_q;
  dals_lock_e st_d;
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic       rx_q;
  logic       rx_d;
  logic       lock_q;
  logic       lock_d;

  // Data path state
  logic signed [SAMPLE_W-1:0] lim_q;
  logic signed [SAMPLE_W-1:0] lim_d;
  logic signed [SAMPLE_W-1:0] filt_q;
  logic signed [SAMPLE_W-1:0] filt_d;
  logic                       v1_q;
  logic                       v1_d;
  logic                       dout_q;
  logic                       dout_d;
  logic                       dval_q;
  logic                       dval_d;

  // Decoded controls
  logic         modem_rst;
  logic         lock_in;
  logic         lock_manual;
  logic         peak_en;
  dals_settle_t settle;
  logic [6:0]   settle_cnt;
  logic         rx_on;
  logic         avg_upd;
  logic signed [SAMPLE_W-1:0] avg_level;

  // Peak remover arithmetic
  logic signed [DW-1:0] diff;
  logic signed [DW-1:0] thr;
  logic signed [DW-1:0] lim_w;
  logic signed [DW-1:0] sum2;

  // Field decode from the control register
  always_comb begin
    lock_in     = ctl_q[`DALS_BIT_LOCK_IN];
    lock_manual = ctl_q[`DALS_BIT_LOCK_MODE];
    peak_en     = ctl_q[`DALS_BIT_PEAK_EN];
    settle      = ctl_q[`DALS_BIT_SETTLE_HI:`DALS_BIT_SETTLE_LO];
    // Either reset source clears the whole modem datapath
    modem_rst   = ~ctl_q[`DALS_BIT_MODEM_RST_N] | ~MAIN_RESET_N;
    rx_on       = ~RX_POWER_DOWN;
  end

  // Settling code to baud count
  always_comb begin
    unique case (settle)
      2'b00: settle_cnt = `DALS_SETTLE_00;
      2'b01: settle_cnt = `DALS_SETTLE_01;
      2'b10: settle_cnt = `DALS_SETTLE_10;
      2'b11: settle_cnt = `DALS_SETTLE_11;
    endcase
  end

  // Register writes; the status bit is not stored here
  always_comb begin
    ctl_d = ctl_q;
    ofs_d = ofs_q;
    if (REG_WR) begin
      if (REG_ADDR == `DALS_OFS_FILTER_CTRL) begin
        ctl_d = REG_WDATA[6:0];
        ctl_d[`DALS_BIT_LOCK_STAT] = 1'b0;
      end
      if (REG_ADDR == `DALS_OFS_PEAK_CTRL) begin
        ofs_d = REG_WDATA[`DALS_THR_HI:0];
      end
    end
  end

  // Read data one cycle after the strobe; unmapped addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    if (REG_RD) begin
      if (REG_ADDR == `DALS_OFS_FILTER_CTRL) begin
        rdata_d = {1'b0, ctl_q};
        rdata_d[`DALS_BIT_LOCK_STAT] = lock_q;
      end else if (REG_ADDR == `DALS_OFS_PEAK_CTRL) begin
        rdata_d = {1'b0, ofs_q};
      end
    end
  end

  // Register file flops
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ctl_q   <= 7'(`DALS_RST_FILTER_CTRL);
      ofs_q   <= `DALS_RST_PEAK_CTRL;
      rdata_q <= 8'h00;
    end else begin
      ctl_q   <= ctl_d;
      ofs_q   <= ofs_d;
      rdata_q <= rdata_d;
    end
  end

  // Automatic lock sequencer; counting restarts on each receive entry
  // until a lock has been reached, after which the lock sticks
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    rx_d  = rx_on;
    if (modem_rst) begin
      st_d  = ST_FREE;
      cnt_d = 7'h00;
      rx_d  = 1'b0;
    end else begin
      unique case (st_q)
        ST_FREE: begin
          if (rx_on && !rx_q) begin
            st_d  = ST_SETTLE;
            cnt_d = 7'h00;
          end
        end
        ST_SETTLE: begin
          if (rx_on && BAUD_TICK) begin
            cnt_d = cnt_q + 7'h01;
            if (cnt_q + 7'h01 >= settle_cnt) begin
              st_d = ST_HOLD;
            end
          end else if (!rx_on) begin
            st_d = ST_FREE;
          end
        end
        ST_HOLD: begin
          st_d = ST_HOLD;
        end
        default: begin
          st_d  = ST_FREE;
          cnt_d = 7'h00;
        end
      endcase
    end
  end

  // Effective lock: manual follows the input bit, automatic the sequencer
  always_comb begin
    if (modem_rst) begin
      lock_d = 1'b0;
    end else if (lock_manual) begin
      lock_d = lock_in;
    end else begin
      lock_d = (st_d == ST_HOLD);
    end
  end

  // Lock state flops
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st_q   <= ST_FREE;
      cnt_q  <= 7'h00;
      rx_q   <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      rx_q   <= rx_d;
      lock_q <= lock_d;
    end
  end

  // Peak remover clamps each step to the offset; off, it passes through
  always_comb begin
    diff  = DW'(SAMPLE) - DW'(lim_q);
    thr   = DW'({1'b0, ofs_q});
    lim_w = DW'(SAMPLE);
    if (peak_en) begin
      if (diff > thr) begin
        lim_w = DW'(lim_q) + thr;
      end else if (diff < -thr) begin
        lim_w = DW'(lim_q) - thr;
      end
    end
  end

  // Data filter: two-tap mean of successive cleaned samples
  always_comb begin
    lim_d  = lim_q;
    filt_d = filt_q;
    v1_d   = 1'b0;
    sum2   = '0;
    if (modem_rst) begin
      lim_d  = '0;
      filt_d = '0;
    end else if (SAMPLE_VALID) begin
      lim_d  = lim_w[SAMPLE_W-1:0];
      sum2   = DW'(lim_d) + DW'(lim_q);
      filt_d = sum2[DW-1:1];
      v1_d   = 1'b1;
    end
  end

  // Averaging filter tracks only while receiving and unlocked, so a held
  // level stays put through power-down and transmit
  always_comb begin
    avg_upd = v1_q && rx_on && !lock_q;
  end

  dals_avg #(
    .W     (SAMPLE_W),
    .SHIFT (AVG_SHIFT)
  ) u_avg (
    .clk   (CLK_SYS),
    .rst   (RST),
    .clr   (modem_rst),
    .upd   (avg_upd),
    .din   (filt_q),
    .level (avg_level)
  );

  // Slicer: one decision per filtered sample
  always_comb begin
    dout_d = dout_q;
    dval_d = 1'b0;
    if (modem_rst) begin
      dout_d = 1'b0;
    end else if (v1_q) begin
      dout_d = (filt_q > avg_level);
      dval_d = 1'b1;
    end
  end

  // Data path flops
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      lim_q  <= '0;
      filt_q <= '0;
      v1_q   <= 1'b0;
      dout_q <= 1'b0;
      dval_q <= 1'b0;
    end else begin
      lim_q  <= lim_d;
      filt_q <= filt_d;
      v1_q   <= v1_d;
      dout_q <= dout_d;
      dval_q <= dval_d;
    end
  end

  // Outputs straight from flops
  assign REG_RDATA  = rdata_q;
  assign DATA_OUT   = dout_q;
  assign DATA_VALID = dval_q;
  assign AVG_LOCKED = lock_q;
  assign AVG_LEVEL  = avg_level;

endmodule // dals_top

`default_nettype wire

/* dals_tx_model.sv */
// Far-side transmitter model: frequency samples of preamble or NRZ bits
`timescale 1ns/1ps
`default_nettype none
module dals_tx_model #(
  parameter int W   = 10,
  parameter int DC  = 100,
  parameter int AMP = 200
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Traffic control
  input  wire logic                en,
  input  wire logic                bal,
  input  wire logic                bitv,
  // Sample stream
  output var  logic                vld,
  output var  logic signed [W-1:0] smp
);
  logic [3:0] cnt_q;
  logic       b;

  // Balanced 0101 preamble flips every two samples
  assign b = bal ? cnt_q[3] : bitv;

  // One sample every four cycles; line scrambles between samples
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      vld   <= 1'b0;
      smp   <= '0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      vld   <= en && cnt_q[1:0] == 2'h0;
      if (en && cnt_q[1:0] == 2'h0)
        smp <= b ? W'(DC + AMP) : W'(DC - AMP);
      else
        smp <= ~smp;
    end
  end
endmodule // dals_tx_model
`default_nettype wire

/* dals_props.sv */
// Port-level properties of the averaging lock and slicer
`timescale 1ns/1ps
`default_nettype none
module dals_props #(
  parameter int SAMPLE_W = 10
) (
  // Clock and reset
  input wire logic                       CLK_SYS,
  input wire logic                       RST,
  // Register port
  input wire logic [7:0]                 REG_ADDR,
  input wire logic [7:0]                 REG_WDATA,
  input wire logic                       REG_WR,
  input wire logic                       REG_RD,
  input wire logic [7:0]                 REG_RDATA,
  // Main RF control
  input wire logic                       MAIN_RESET_N,
  input wire logic                       RX_POWER_DOWN,
  // Samples and decisions
  input wire logic                       SAMPLE_VALID,
  input wire logic                       DATA_OUT,
  input wire logic                       DATA_VALID,
  input wire logic                       AVG_LOCKED,
  input wire logic signed [SAMPLE_W-1:0] AVG_LEVEL
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // Writes reach the datapath two edges late, so they are excluded
  a_rd_idle_zero: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data outside slot");
  a_rsvd_zero: assert property (REG_RDATA[7] == 1'b0)
    else $error("reserved bit set");
  a_dv_latency: assert property (DATA_VALID |-> $past(SAMPLE_VALID, 2))
    else $error("decision without sample");
  a_stat_bit: assert property (REG_RD && REG_ADDR == 8'hda |=>
    REG_RDATA[4] == $past(AVG_LOCKED)) else $error("status bit wrong");
  a_main_clear: assert property (!MAIN_RESET_N [*3] |->
    AVG_LEVEL == 0 && !DATA_OUT) else $error("main reset no clear");
  a_lock_freeze: assert property (AVG_LOCKED && $past(AVG_LOCKED) &&
    $past(MAIN_RESET_N) && !$past(REG_WR) && !$past(REG_WR, 2)
    |-> $stable(AVG_LEVEL)) else $error("locked level moved");
  a_pd_hold: assert property ((RX_POWER_DOWN && MAIN_RESET_N &&
    !REG_WR) [*4] |-> $stable(AVG_LEVEL)) else $error("level moved off rx");
  a_dout_hold: assert property (!DATA_VALID && $past(MAIN_RESET_N) &&
    !$past(REG_WR) && !$past(REG_WR, 2) |-> $stable(DATA_OUT))
    else $error("decision moved");
  a_man_lock: assert property (REG_WR && REG_ADDR == 8'hda &&
    REG_WDATA[6:5] == 2'b11 && REG_WDATA[0] && MAIN_RESET_N ##1
    (!REG_WR && MAIN_RESET_N) |=> AVG_LOCKED) else $error("no manual lock");

  // Main scenarios reached
  c_lock_rise: cover property ($rose(AVG_LOCKED));
  c_one_bit: cover property (DATA_VALID && DATA_OUT);
  c_stat_read: cover property (REG_RD && REG_ADDR == 8'hda);
endmodule // dals_props
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the averaging lock and slicer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic              clk = 0, rst = 1, we = 0, re = 0, tick = 0;
  logic              mrst_n = 1, pd = 1, en = 0, bal = 1, bitv = 0;
  logic [7:0]        a = 8'h00, wd = 8'h00, rdat, r;
  logic              sv, dout, dv, lock;
  logic signed [9:0] smp, lvl;
  logic [15:0]       hold;
  int                bad_count = 0, checks = 0, cyc = 0;
  int                nb[4] = '{11, 22, 43, 86};

  // 40 MHz system clock
  always #12.5 clk = ~clk;

  dals_tx_model u_tx (.clk(clk), .rst(rst), .en(en), .bal(bal),
    .bitv(bitv), .vld(sv), .smp(smp));
  dals_top uut (.CLK_SYS(clk), .RST(rst), .REG_ADDR(a), .REG_WDATA(wd),
    .REG_WR(we), .REG_RD(re), .REG_RDATA(rdat), .MAIN_RESET_N(mrst_n),
    .RX_POWER_DOWN(pd), .BAUD_TICK(tick), .SAMPLE_VALID(sv), .SAMPLE(smp),
    .DATA_OUT(dout), .DATA_VALID(dv), .AVG_LOCKED(lock), .AVG_LEVEL(lvl));

  task chk(string n, logic [15:0] e, logic [15:0] g);
    checks++;
    if (e !== g) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task cy(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(logic [7:0] ad, logic [7:0] d);
    @(posedge clk);
    a <= ad; wd <= d; we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task rd(logic [7:0] ad, output logic [7:0] d);
    @(posedge clk);
    a <= ad; re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 d = rdat;
  endtask
  // Waits for n decisions; a missing one counts as a mismatch
  task dec(int n);
    int i;
    repeat (n) begin
      i = 0;
      cy(1);
      while (dv !== 1'b1 && i < 99) begin
        cy(1);
        i++;
      end
      chk("decision", 1'b1, dv);
    end
  endtask
  task tk(int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      cy(2);
    end
  endtask

  task t_regs;
    rd(8'hda, r); chk("ctrl reset", 8'h00, r);
    rd(8'hd9, r); chk("peak reset", 8'h00, r);
    wr(8'hda, 8'hff); wr(8'hd9, 8'hff); cy(3);
    rd(8'hda, r); chk("ctrl", 8'h7f, r);
    rd(8'hd9, r); chk("peak", 8'h7f, r);
    rd(8'h10, r); chk("unmapped", 8'h00, r);
    $display("test regs done");
  endtask
  // Acquire on preamble, lock, then slice NRZ ones and zeros
  task t_slice;
    @(posedge clk);
    en <= 1; pd <= 0;
    wr(8'hda, 8'h21); cy(300);
    wr(8'hda, 8'h61); cy(3); hold = lvl;
    // Free-running filter must have settled near the preamble's mean level
    chk("acquired", 1'b1, lvl > 10'sd60 && lvl < 10'sd140);
    bal <= 0; bitv <= 1; dec(4); chk("one", 1'b1, dout);
    bitv <= 0; dec(4); chk("zero", 1'b0, dout);
    chk("held level", hold, lvl);
    wr(8'hd9, 8'h01); wr(8'hda, 8'h63); bitv <= 1; dec(6);
    chk("peak on", 1'b0, dout);
    wr(8'hda, 8'h61); dec(6); chk("peak off", 1'b1, dout);
    $display("test slice done");
  endtask
  task t_srst;
    int n;
    n = 0;
    wr(8'hda, 8'h00); cy(3);
    chk("soft lock", 1'b0, lock);
    chk("soft level", 16'h0000, lvl);
    repeat (40) begin
      cy(1);
      if (dv !== 1'b0) n++;
    end
    chk("dropped", 16'h0000, n[15:0]);
    $display("test soft reset done");
  endtask
  task t_auto(logic [1:0] c);
    @(posedge clk);
    pd <= 1; mrst_n <= 0; bal <= 1; cy(4);
    chk("main level", 16'h0000, lvl);
    @(posedge clk);
    mrst_n <= 1; wr(8'hda, {4'h0, c, 2'b01}); pd <= 0;
    tk(nb[c] - 1); chk("early", 1'b0, lock);
    tk(1); chk("locked", 1'b1, lock);
    rd(8'hda, r); chk("stat", {4'h1, c, 2'b01}, r);
    hold = lvl;
    @(posedge clk);
    pd <= 1; tk(4);
    chk("sticky", 1'b1, lock);
    chk("kept level", hold, lvl);
    $display("test auto lock done");
  endtask

  // Cycle ceiling well above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin bad_count++; conclude; end
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    t_regs;
    t_slice;
    t_srst;
    for (int c = 0; c < 4; c++) t_auto(c[1:0]);
    conclude;
  end
endmodule // testbench

bind dals_top dals_props #(.SAMPLE_W(SAMPLE_W)) u_props (
  .CLK_SYS(CLK_SYS), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .MAIN_RESET_N(MAIN_RESET_N), .RX_POWER_DOWN(RX_POWER_DOWN),
  .SAMPLE_VALID(SAMPLE_VALID), .DATA_OUT(DATA_OUT), .DATA_VALID(DATA_VALID),
  .AVG_LOCKED(AVG_LOCKED), .AVG_LEVEL(AVG_LEVEL));
`default_nettype wire
